// >>> hw/ch3cal_regs.sv
// Channel 3 calibration register bank with AHB-Lite slave and result correction
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
// What this block does
// RULE1 - The low offset word keeps offset bits 7:0 in its bits 15:8, read and write.
// RULE2 - Bits 7:0 of the low offset word always read as zero, whatever was written.
// RULE3 - The high gain word sits at index 1Bh and resets to 8000h, a gain of one.
// RULE4 - All 16 bits of the high gain word are read and write and hold gain bits 23:8.
// RULE5 - The 24-bit gain is unsigned, spanning 0.0 to just under 2.0 in steps of 2^-24 of two.
// RULE6 - The low gain word sits at index 1Ch and resets to zero.
// RULE7 - The low gain word keeps gain bits 7:0 in bits 15:8 and reads zero in bits 7:0.
// RULE8 - Each channel 3 result gets the 24-bit offset added, then is scaled by the 24-bit gain.
module ch3cal_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] ch3_offset_high_bits,
  input wire ch3cal_pkg::ch3cal_sample_t sample_in,
  output ch3cal_pkg::ch3cal_sample_t sample_out
);

  ch3cal_pkg::ch3cal_req_t addr_req;
  ch3cal_pkg::ch3cal_req_t data_req;
  ch3cal_pkg::ch3cal_cal_t cal;
  ch3cal_pkg::ch3cal_sample_t corrected;

  logic [7:0] ch3_offset_low_bits;
  logic [15:0] ch3_gain_high_bits;
  logic [7:0] ch3_gain_low_bits;
  logic corr_enable;
  logic sat_flag;
  logic [15:0] sample_count;
  logic [23:0] last_result;
  logic sat_event;

  logic [7:0] next_offset_low_bits;
  logic [15:0] next_gain_high_bits;
  logic [7:0] next_gain_low_bits;
  logic next_corr_enable;
  logic next_sat_flag;
  logic [15:0] next_sample_count;
  logic [23:0] next_last_result;
  logic [31:0] next_hrdata;
  logic wr_hit;
  logic sat_clear;

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = ch3cal_pkg::HRESP_OKAY;

  // Address phase decode
  always_comb begin
    addr_req = '0;
    if (hsel && hready && htrans[1] && (hsize == ch3cal_pkg::HSIZE_WORD)) begin
      addr_req.write = hwrite;
      addr_req.read = !hwrite;
      addr_req.index = haddr[ch3cal_pkg::IDX_MSB:ch3cal_pkg::IDX_LSB];
    end
  end

  // Held write request for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_req <= '0;
    end else if (hready) begin
      data_req <= addr_req;
    end
  end

  assign wr_hit = data_req.write;

  // RULE1 - offset field writable
  always_comb begin
    next_offset_low_bits = ch3_offset_low_bits;
    if (wr_hit && data_req.index == ch3cal_pkg::IDX_OFFSET_CAL_LOW) begin
      next_offset_low_bits = hwdata[ch3cal_pkg::LOW_FIELD_MSB:ch3cal_pkg::LOW_FIELD_LSB];
    end
  end

  // RULE4 - full word writable
  always_comb begin
    next_gain_high_bits = ch3_gain_high_bits;
    if (wr_hit && data_req.index == ch3cal_pkg::IDX_GAIN_CAL_HIGH) begin
      next_gain_high_bits = hwdata[ch3cal_pkg::WORD_MSB:0];
    end
  end

  // RULE7 - gain low field writable
  always_comb begin
    next_gain_low_bits = ch3_gain_low_bits;
    if (wr_hit && data_req.index == ch3cal_pkg::IDX_GAIN_CAL_LOW) begin
      next_gain_low_bits = hwdata[ch3cal_pkg::LOW_FIELD_MSB:ch3cal_pkg::LOW_FIELD_LSB];
    end
  end

  always_comb begin
    next_corr_enable = corr_enable;
    if (wr_hit && data_req.index == ch3cal_pkg::IDX_CTRL) begin
      next_corr_enable = hwdata[ch3cal_pkg::CTRL_ENABLE_BIT];
    end
  end

  // Sticky saturation flag, set beats clear
  assign sat_clear = wr_hit && (data_req.index == ch3cal_pkg::IDX_STATUS) && hwdata[ch3cal_pkg::STATUS_SAT_BIT];
  assign next_sat_flag = sat_event || (sat_flag && !sat_clear);

  always_comb begin
    next_sample_count = sample_count;
    next_last_result = last_result;
    if (corrected.valid) begin
      next_sample_count = sample_count + 16'h0001;
      next_last_result = corrected.data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch3_offset_low_bits <= ch3cal_pkg::RST_OFFSET_LOW_BITS;
    end else begin
      ch3_offset_low_bits <= next_offset_low_bits;
    end
  end

  // RULE3 - gain resets to one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch3_gain_high_bits <= ch3cal_pkg::RST_GAIN_CAL_HIGH;
    end else begin
      ch3_gain_high_bits <= next_gain_high_bits;
    end
  end

  // RULE6 - low gain resets zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch3_gain_low_bits <= ch3cal_pkg::RST_GAIN_LOW_BITS;
    end else begin
      ch3_gain_low_bits <= next_gain_low_bits;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr_enable <= ch3cal_pkg::RST_CORR_ENABLE;
    end else begin
      corr_enable <= next_corr_enable;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sat_flag <= 1'b0;
      sample_count <= ch3cal_pkg::RST_SAMPLE_COUNT;
      last_result <= ch3cal_pkg::RST_RESULT;
    end else begin
      sat_flag <= next_sat_flag;
      sample_count <= next_sample_count;
      last_result <= next_last_result;
    end
  end

  // Read mux sees values after a write in the same cycle
  always_comb begin
    next_hrdata = ch3cal_pkg::READ_ZERO;
    if (addr_req.read) begin
      unique case (addr_req.index)
        // RULE2 - reserved byte zero
        ch3cal_pkg::IDX_OFFSET_CAL_LOW: begin
          next_hrdata = {16'h0000, next_offset_low_bits, ch3cal_pkg::RESERVED_BYTE};
        end
        ch3cal_pkg::IDX_GAIN_CAL_HIGH: begin
          next_hrdata = {16'h0000, next_gain_high_bits};
        end
        // RULE7 - reserved byte zero
        ch3cal_pkg::IDX_GAIN_CAL_LOW: begin
          next_hrdata = {16'h0000, next_gain_low_bits, ch3cal_pkg::RESERVED_BYTE};
        end
        ch3cal_pkg::IDX_CTRL: begin
          next_hrdata[ch3cal_pkg::CTRL_ENABLE_BIT] = next_corr_enable;
        end
        ch3cal_pkg::IDX_STATUS: begin
          next_hrdata[ch3cal_pkg::STATUS_SAT_BIT] = next_sat_flag;
          next_hrdata[ch3cal_pkg::STATUS_COUNT_MSB:ch3cal_pkg::STATUS_COUNT_LSB] = next_sample_count;
        end
        ch3cal_pkg::IDX_RESULT: begin
          next_hrdata = {8'h00, next_last_result};
        end
        default: begin
          next_hrdata = ch3cal_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= ch3cal_pkg::READ_ZERO;
    end else if (hready) begin
      hrdata <= next_hrdata;
    end
  end

  // RULE8 - words joined to 24 bits
  always_comb begin
    cal.enable = corr_enable;
    cal.offset = {ch3_offset_high_bits, ch3_offset_low_bits};
    cal.gain = {ch3_gain_high_bits, ch3_gain_low_bits};
  end

  ch3cal_corrector u_corrector (
    .hclk(hclk),
    .hresetn(hresetn),
    .cal(cal),
    .sample_in(sample_in),
    .sample_out(corrected),
    .saturated(sat_event)
  );

  assign sample_out = corrected;

endmodule : ch3cal_regs

// >>> hw/ch3cal_pkg.sv
// Shared constants and types for the channel 3 calibration register bank
package ch3cal_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_OFFSET_CAL_LOW = 8'h1a;
  localparam logic [7:0] IDX_GAIN_CAL_HIGH = 8'h1b;
  localparam logic [7:0] IDX_GAIN_CAL_LOW = 8'h1c;
  localparam logic [7:0] IDX_CTRL = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_RESULT = 8'h42;

  // Word index taken from haddr
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;

  // Reset values
  localparam logic [15:0] RST_GAIN_CAL_HIGH = 16'h8000;
  localparam logic [7:0] RST_GAIN_LOW_BITS = 8'h00;
  localparam logic [7:0] RST_OFFSET_LOW_BITS = 8'h00;
  localparam logic RST_CORR_ENABLE = 1'b1;
  localparam logic [15:0] RST_SAMPLE_COUNT = 16'h0000;
  localparam logic [23:0] RST_RESULT = 24'h00_0000;

  // Field positions
  localparam int unsigned LOW_FIELD_MSB = 15;
  localparam int unsigned LOW_FIELD_LSB = 8;
  localparam int unsigned WORD_MSB = 15;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned STATUS_SAT_BIT = 0;
  localparam int unsigned STATUS_COUNT_LSB = 16;
  localparam int unsigned STATUS_COUNT_MSB = 31;

  // Reserved low byte of the low words
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // Data path
  localparam int unsigned DATA_W = 24;
  localparam int unsigned GAIN_FRAC_BITS = 23;

  // AHB-Lite codes
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic valid;
    logic signed [DATA_W-1:0] data;
  } ch3cal_sample_t;

  typedef struct packed {
    logic enable;
    logic [DATA_W-1:0] offset;
    logic [DATA_W-1:0] gain;
  } ch3cal_cal_t;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] index;
  } ch3cal_req_t;

endpackage : ch3cal_pkg

// >>> hw/ch3cal_corrector.sv
// Two-stage offset and gain correction of channel 3 conversion results
`timescale 1ns/10ps
module ch3cal_corrector (
  input wire logic hclk,
  input wire logic hresetn,
  input wire ch3cal_pkg::ch3cal_cal_t cal,
  input wire ch3cal_pkg::ch3cal_sample_t sample_in,
  output ch3cal_pkg::ch3cal_sample_t sample_out,
  output logic saturated
);

  localparam int unsigned SUM_W = ch3cal_pkg::DATA_W + 1;
  localparam int unsigned PROD_W = 2 * SUM_W;
  localparam int unsigned SHIFT_W = PROD_W - ch3cal_pkg::GAIN_FRAC_BITS;
  localparam int unsigned DW = ch3cal_pkg::DATA_W;

  logic stage1_valid;
  logic stage1_enable;
  logic signed [SUM_W-1:0] stage1_sum;
  logic signed [DW-1:0] stage1_raw;
  logic signed [PROD_W-1:0] product;
  logic signed [SHIFT_W-1:0] scaled;
  logic overflow;
  logic signed [DW-1:0] clipped;

  // RULE8 - offset added first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_valid <= 1'b0;
      stage1_enable <= 1'b0;
      stage1_sum <= '0;
      stage1_raw <= '0;
    end else begin
      stage1_valid <= sample_in.valid;
      if (sample_in.valid) begin
        stage1_enable <= cal.enable;
        stage1_sum <= SUM_W'($signed(sample_in.data)) + SUM_W'($signed(cal.offset));
        stage1_raw <= sample_in.data;
      end
    end
  end

  // RULE5 - gain taken unsigned
  assign product = stage1_sum * $signed({1'b0, cal.gain});
  assign scaled = product[PROD_W-1:ch3cal_pkg::GAIN_FRAC_BITS];
  assign overflow = (scaled[SHIFT_W-1:DW-1] != {(SHIFT_W-DW+1){1'b0}}) &&
                    (scaled[SHIFT_W-1:DW-1] != {(SHIFT_W-DW+1){1'b1}});
  assign clipped = overflow ? {scaled[SHIFT_W-1], {(DW-1){~scaled[SHIFT_W-1]}}} : scaled[DW-1:0];

  // RULE8 - gain applied second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sample_out <= '0;
      saturated <= 1'b0;
    end else begin
      sample_out.valid <= stage1_valid;
      saturated <= stage1_valid && stage1_enable && overflow;
      if (stage1_valid) begin
        sample_out.data <= stage1_enable ? clipped : stage1_raw;
      end
    end
  end

endmodule : ch3cal_corrector

// >>> tb/ch3cal_regs_chk.sv
// Port-level assertions for the channel 3 calibration register bank
`timescale 1ns/10ps
module ch3cal_regs_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [15:0] ch3_offset_high_bits,
  input wire ch3cal_pkg::ch3cal_sample_t sample_in,
  input wire ch3cal_pkg::ch3cal_sample_t sample_out
);
  logic acc;
  logic [7:0] idx;
  assign acc = hsel && hready && htrans[1] && hsize == ch3cal_pkg::HSIZE_WORD;
  assign idx = haddr[9:2];
  // Register half of the write data, the part the gain word keeps
  logic [15:0] wlo;
  assign wlo = hwdata[15:0];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout == 1'b1) else $error("hreadyout dropped");
  AST_OKAY: assert property (hresp == ch3cal_pkg::HRESP_OKAY) else $error("hresp not okay");
  AST_OFS_RSVD: assert property (
    acc && !hwrite && idx == ch3cal_pkg::IDX_OFFSET_CAL_LOW |=> hrdata[7:0] == 8'h00 && hrdata[31:16] == 16'h0000)
    else $error("offset low reserved bits not zero");
  AST_GLO_RSVD: assert property (
    acc && !hwrite && idx == ch3cal_pkg::IDX_GAIN_CAL_LOW |=> hrdata[7:0] == 8'h00 && hrdata[31:16] == 16'h0000)
    else $error("gain low reserved bits not zero");
  AST_GHI_UPPER: assert property (
    acc && !hwrite && idx == ch3cal_pkg::IDX_GAIN_CAL_HIGH |=> hrdata[31:16] == 16'h0000)
    else $error("gain high upper half not zero");
  AST_GHI_WRRD: assert property (
    (acc && hwrite && idx == ch3cal_pkg::IDX_GAIN_CAL_HIGH) ##2 (acc && !hwrite && idx == ch3cal_pkg::IDX_GAIN_CAL_HIGH)
    |=> hrdata[15:0] == $past(wlo, 2)) else $error("gain high readback differs from write");
  AST_UNMAP: assert property (
    acc && !hwrite && !(idx inside {8'h1a, 8'h1b, 8'h1c, 8'h40, 8'h41, 8'h42}) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_LAT: assert property (sample_in.valid |-> ##2 sample_out.valid) else $error("result not out after 2");
  AST_NOSPUR: assert property (
    sample_out.valid |-> $past(sample_in.valid, 2) && !$past(sample_in.valid, 1) || $past(sample_in.valid, 2))
    else $error("result without a sample");
endmodule : ch3cal_regs_chk

bind ch3cal_regs ch3cal_regs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .ch3_offset_high_bits(ch3_offset_high_bits), .sample_in(sample_in), .sample_out(sample_out));

// >>> tb/test_ch3cal_regs.sv
// Self-checking bench for the channel 3 calibration register bank
`timescale 1ns/10ps
module test_ch3cal_regs;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, d;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic hreadyout, hresp;
  logic [15:0] ofs_hi = 16'h0000, olo, ghi, glo;
  ch3cal_pkg::ch3cal_sample_t sample_in = '0, sample_out;
  logic signed [23:0] x;
  logic [15:0] n_samp = 16'h0000;
  integer n_errors = 0, n_compared = 0, seed = 32'h9800_d377, i;

  ch3cal_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ch3_offset_high_bits(ofs_hi), .sample_in(sample_in), .sample_out(sample_out));

  always #4 hclk = ~hclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer

  function automatic logic [23:0] corr(input logic signed [23:0] v, input logic [23:0] off, input logic [23:0] g);
    logic signed [24:0] s;
    logic signed [50:0] p;
    s = {v[23], v} + {off[23], off};
    p = (s * $signed({1'b0, g})) >>> 23;
    if (p > 51'sh7f_ffff) return 24'h7f_ffff;
    if (p < -51'sh80_0000) return 24'h80_0000;
    return p[23:0];
  endfunction : corr

  task samp(input logic signed [23:0] v, input logic [23:0] exp);
    sample_in <= {1'b1, v};
    @(posedge hclk);
    sample_in <= '0;
    for (int k = 0; k < 8 && sample_out.valid !== 1'b1; k++) @(posedge hclk);
    n_samp = n_samp + 16'h0001;
    check({31'h0000_0000, sample_out.valid}, 32'h0000_0001);
    check({8'h00, sample_out.data}, {8'h00, exp});
  endtask : samp

  initial begin
    #50_000;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 8'h1b, 32'h0, d); check(d, 32'h0000_8000);
    xfer(1'b0, 8'h1c, 32'h0, d); check(d, 32'h0000_0000);
    xfer(1'b0, 8'h1a, 32'h0, d); check(d, 32'h0000_0000);
    xfer(1'b0, 8'h55, 32'h0, d); check(d, 32'h0000_0000);
    // Identity gain passes the sample through
    samp(24'h12_3456, 24'h12_3456);
    $display("reset and identity test done");
    for (i = 0; i < 12; i++) begin
      olo = 16'($random(seed));
      ghi = (i == 0) ? 16'hffff : 16'($random(seed));
      glo = (i == 0) ? 16'hffff : 16'($random(seed));
      x = (i == 1) ? 24'h7f_ffff : 24'($random(seed));
      ofs_hi <= (i == 1) ? 16'h7fff : 16'($random(seed));
      xfer(1'b1, 8'h1a, {16'hffff, olo}, d);
      xfer(1'b0, 8'h1a, 32'h0, d); check(d, {16'h0000, olo[15:8], 8'h00});
      xfer(1'b1, 8'h1b, {16'hffff, ghi}, d);
      xfer(1'b0, 8'h1b, 32'h0, d); check(d, {16'h0000, ghi});
      xfer(1'b1, 8'h1c, {16'hffff, glo}, d);
      xfer(1'b0, 8'h1c, 32'h0, d); check(d, {16'h0000, glo[15:8], 8'h00});
      xfer(1'b1, 8'h55, 32'hffff_ffff, d);
      xfer(1'b0, 8'h1b, 32'h0, d); check(d, {16'h0000, ghi});
      // Unsigned gain near two, saturating offset
      samp(x, corr(x, {ofs_hi, olo[15:8]}, {ghi, glo[15:8]}));
    end
    $display("random calibration test done");
    // Saturating corner, sticky flag, bypass
    xfer(1'b0, 8'h40, 32'h0, d); check(d, 32'h0000_0001);
    ofs_hi <= 16'h7fff;
    xfer(1'b1, 8'h1a, 32'h0000_ff00, d);
    xfer(1'b1, 8'h1b, 32'h0000_ffff, d);
    xfer(1'b1, 8'h1c, 32'h0000_ff00, d);
    samp(24'h7f_ffff, corr(24'h7f_ffff, 24'h7f_ffff, 24'hff_ffff));
    xfer(1'b0, 8'h41, 32'h0, d); check(d, {n_samp, 16'h0001});
    xfer(1'b1, 8'h41, 32'h0000_0001, d);
    xfer(1'b0, 8'h41, 32'h0, d); check(d, {n_samp, 16'h0000});
    xfer(1'b1, 8'h40, 32'h0, d);
    xfer(1'b0, 8'h40, 32'h0, d); check(d, 32'h0000_0000);
    samp(24'h80_0001, 24'h80_0001);
    xfer(1'b0, 8'h42, 32'h0, d); check(d, 32'h0080_0001);
    xfer(1'b0, 8'h41, 32'h0, d); check(d, {n_samp, 16'h0000});
    hsel <= 1'b0;
    $display("saturation and bypass test done");
    summarize();
  end
endmodule : test_ch3cal_regs
